// File: logic/gsc_status_control.sv
/*
  Gateway status and control process-data words: takes the control word from
  the fieldbus master, steers sync, resend and CRC checking, and builds the
  32-bit status word. Assumes the fieldbus slave presents the control word
  with a one-cycle write strobe, the configuration is presented with a
  one-cycle load strobe after power-up, and engine events are one-cycle pulses.
*/
`timescale 1ns/1ns
`default_nettype none
`include "gsc_defs.svh"

module gsc_status_control
  import gsc_pkg::*;
#(
  parameter int CTRL_WIDTH = 32,
  parameter int STATUS_WIDTH = 32
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [CTRL_WIDTH-1:0] controlWord,
  input wire logic controlWrite,
  input wire logic initStrapShorted,
  input wire gsc_config_s configData,
  input wire logic configLoad,
  input wire logic configFromDefaults,
  input wire gsc_events_s engineEvents,
  output logic [STATUS_WIDTH-1:0] statusWord,
  output gsc_steer_s steer,
  output logic syncActive,
  output logic errorLed,
  output logic debugMode
);

  if (CTRL_WIDTH < 6 || STATUS_WIDTH != 32) begin : g_bad_params
    $error("gsc_status_control: control needs 6 bits, status must be 32");
  end

  gsc_boot_e bootState;
  gsc_boot_e next_bootState;
  logic [CTRL_WIDTH-1:0] control;
  gsc_config_s activeCfg;
  logic cfgValid;
  logic strapSeen;

  // Control word decode
  wire logic ctlSyncRun = control[`GSC_CTL_SYNC_RUN];
  wire logic ctlSyncEnable = control[`GSC_CTL_SYNC_EN];
  wire logic ctlNoResend = control[`GSC_CTL_NO_RESEND];
  wire logic ctlSkipCrc = control[`GSC_CTL_NO_CRC];
  wire logic ctlInitReady = control[`GSC_CTL_INIT_READY];
  // Clear acts in the cycle the master writes the bit, not while it stays high,
  // so a held clear bit cannot mask errors raised later.
  wire logic clearReq = controlWrite & controlWord[`GSC_CTL_CLEAR];

  // Configuration checks on the incoming configuration
  wire logic cfgBaudBad = (configData.baudCode < `GSC_BAUD_CODE_MIN)
    || (configData.baudCode > `GSC_BAUD_CFG_MAX);
  wire logic cfgParityBad = (configData.parity == GSC_PAR_BAD);
  wire logic cfgStopBad = (configData.stopBits != 2'h1)
    && (configData.stopBits != 2'h2);
  wire logic cfgTmoBad = (configData.timeoutMs > `GSC_TMO_MS_MAX);
  wire logic cfgDelayBad = (configData.delayMs > `GSC_DELAY_MS_MAX);
  wire logic cfgCountBad = (configData.cmdCount > `GSC_CMD_COUNT_MAX);

  wire logic [11:0] cfgErrVec = {
    configData.inOutMaxBad,
    configData.cmdFunctionBad,
    configData.cmdLengthBad,
    cfgCountBad,
    configData.eepCrcBad,
    configData.addressBad,
    cfgDelayBad,
    cfgTmoBad,
    cfgStopBad,
    cfgParityBad,
    cfgBaudBad,
    1'b0
  };
  wire logic anyCfgErr = |cfgErrVec;
  wire logic [11:0] cfgSet = configLoad ? cfgErrVec : 12'h000;

  // Engine events; a CRC fault is not reported while checking is skipped
  wire logic evCrc = engineEvents.crcBad & ~ctlSkipCrc;
  wire logic evFc = engineEvents.functionCodeBad;
  wire logic evNode = engineEvents.nodeIdBad;
  wire logic evTmo = engineEvents.timeout;

  // Sticky flags: low half strap and config errors, then runtime errors. One named
  // instance per flag, so each status bit traces to its own set source.
  logic [11:1] lowFlags;
  logic strapFlag;
  logic [3:0] runFlags;
  logic configFromDefaultsHeld;

  gsc_sticky_bit u_baud_err (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .setPulse(cfgSet[`GSC_ST_BAUD_ERR]),
    .clearReq(clearReq),
    .flag(lowFlags[`GSC_ST_BAUD_ERR])
  );

  gsc_sticky_bit u_parity_err (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .setPulse(cfgSet[`GSC_ST_PARITY_ERR]),
    .clearReq(clearReq),
    .flag(lowFlags[`GSC_ST_PARITY_ERR])
  );

  gsc_sticky_bit u_stop_err (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .setPulse(cfgSet[`GSC_ST_STOP_ERR]),
    .clearReq(clearReq),
    .flag(lowFlags[`GSC_ST_STOP_ERR])
  );

  gsc_sticky_bit u_tmo_cfg_err (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .setPulse(cfgSet[`GSC_ST_TMO_CFG_ERR]),
    .clearReq(clearReq),
    .flag(lowFlags[`GSC_ST_TMO_CFG_ERR])
  );

  gsc_sticky_bit u_delay_err (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .setPulse(cfgSet[`GSC_ST_DELAY_ERR]),
    .clearReq(clearReq),
    .flag(lowFlags[`GSC_ST_DELAY_ERR])
  );

  gsc_sticky_bit u_addr_err (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .setPulse(cfgSet[`GSC_ST_ADDR_ERR]),
    .clearReq(clearReq),
    .flag(lowFlags[`GSC_ST_ADDR_ERR])
  );

  gsc_sticky_bit u_eep_crc_err (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .setPulse(cfgSet[`GSC_ST_EEP_CRC_ERR]),
    .clearReq(clearReq),
    .flag(lowFlags[`GSC_ST_EEP_CRC_ERR])
  );

  gsc_sticky_bit u_cnt_err (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .setPulse(cfgSet[`GSC_ST_CNT_ERR]),
    .clearReq(clearReq),
    .flag(lowFlags[`GSC_ST_CNT_ERR])
  );

  gsc_sticky_bit u_len_err (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .setPulse(cfgSet[`GSC_ST_LEN_ERR]),
    .clearReq(clearReq),
    .flag(lowFlags[`GSC_ST_LEN_ERR])
  );

  gsc_sticky_bit u_fun_err (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .setPulse(cfgSet[`GSC_ST_FUN_ERR]),
    .clearReq(clearReq),
    .flag(lowFlags[`GSC_ST_FUN_ERR])
  );

  gsc_sticky_bit u_inout_err (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .setPulse(cfgSet[`GSC_ST_INOUT_ERR]),
    .clearReq(clearReq),
    .flag(lowFlags[`GSC_ST_INOUT_ERR])
  );

  gsc_sticky_bit u_crc_err (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .setPulse(evCrc),
    .clearReq(clearReq),
    .flag(runFlags[3])
  );

  gsc_sticky_bit u_fc_err (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .setPulse(evFc),
    .clearReq(clearReq),
    .flag(runFlags[2])
  );

  gsc_sticky_bit u_node_err (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .setPulse(evNode),
    .clearReq(clearReq),
    .flag(runFlags[1])
  );

  gsc_sticky_bit u_tmo_err (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .setPulse(evTmo),
    .clearReq(clearReq),
    .flag(runFlags[0])
  );

  // Strap indication re-asserts after a clear while the strap stays seen
  wire logic strapSet = strapSeen;
  // Bit 17 is a level, not an error flag: it follows the adopted configuration
  wire logic initValFlag = cfgValid & configFromDefaultsHeld;

  gsc_sticky_bit u_strap (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .setPulse(strapSet),
    .clearReq(clearReq),
    .flag(strapFlag)
  );

  // Runtime serial settings from the active configuration
  wire logic [3:0] runBaud = cfgValid ? activeCfg.baudCode : 4'h0;
  wire logic runEven = cfgValid & (activeCfg.parity == GSC_PAR_EVEN);
  wire logic runOdd = cfgValid & (activeCfg.parity == GSC_PAR_ODD);
  wire logic runTwoStop = cfgValid & (activeCfg.stopBits == 2'h2);
  wire logic runDefault = cfgValid
    & (activeCfg.baudCode == `GSC_BAUD_CODE_DEFAULT)
    & (activeCfg.parity == GSC_PAR_NONE)
    & (activeCfg.stopBits == 2'h1);
  // Sync runs only with the mechanism enabled and the run bit high
  wire logic syncOn = ctlSyncEnable & ctlSyncRun;

  // Status word assembly; a clear this cycle empties the whole word
  wire logic [STATUS_WIDTH-1:0] next_statusWord = clearReq ? `GSC_STATUS_RESET : {
    runBaud,
    runEven,
    runOdd,
    runTwoStop,
    runDefault,
    2'b00,
    syncOn,
    runFlags[3],
    runFlags[2],
    runFlags[1],
    initValFlag,
    runFlags[0],
    4'h0,
    lowFlags[11:1],
    strapFlag
  };

  // Boot sequencing
  always_comb begin
    next_bootState = bootState;
    case (bootState)
      GSC_BOOT_CHECK: begin
        if (strapSeen) begin
          next_bootState = GSC_BOOT_DEBUG;
        end else if (configLoad) begin
          next_bootState = anyCfgErr ? GSC_BOOT_ERROR : GSC_BOOT_RUN;
        end
      end
      GSC_BOOT_RUN: begin
        if (strapSeen) begin
          next_bootState = GSC_BOOT_DEBUG;
        end else if (configLoad && anyCfgErr) begin
          next_bootState = GSC_BOOT_ERROR;
        end
      end
      GSC_BOOT_ERROR: begin
        if (strapSeen) begin
          next_bootState = GSC_BOOT_DEBUG;
        end else if (configLoad && !anyCfgErr) begin
          next_bootState = GSC_BOOT_RUN;
        end
      end
      GSC_BOOT_DEBUG: begin
        next_bootState = GSC_BOOT_DEBUG;
      end
      default: begin
        next_bootState = GSC_BOOT_CHECK;
      end
    endcase
  end

  wire gsc_steer_s next_steer = '{
    syncEnable: ctlSyncEnable,
    syncRun: syncOn,
    noResend: ctlNoResend,
    skipCrc: ctlSkipCrc,
    initialReady: ctlInitReady
  };

  // Control word capture
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      control <= '0;
    end else if (controlWrite) begin
      control <= controlWord;
    end
  end

  // Configuration capture; strap is sampled after reset release
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      activeCfg <= '0;
      cfgValid <= 1'b0;
      configFromDefaultsHeld <= 1'b0;
      strapSeen <= 1'b0;
    end else begin
      strapSeen <= strapSeen | initStrapShorted;
      if (configLoad && !anyCfgErr) begin
        activeCfg <= configData;
        cfgValid <= 1'b1;
        configFromDefaultsHeld <= configFromDefaults;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bootState <= GSC_BOOT_CHECK;
      statusWord <= `GSC_STATUS_RESET;
      steer <= '0;
      syncActive <= 1'b0;
      errorLed <= 1'b0;
      debugMode <= 1'b0;
    end else begin
      bootState <= next_bootState;
      statusWord <= next_statusWord;
      steer <= next_steer;
      syncActive <= syncOn;
      errorLed <= (next_bootState == GSC_BOOT_ERROR);
      debugMode <= (next_bootState == GSC_BOOT_DEBUG);
    end
  end

endmodule : gsc_status_control

`default_nettype wire

// File: logic/gsc_defs.svh
/*
  Offsets, field positions, reset values and configuration limits of the gateway
  status and control words. Assumes inclusion by bare name, once per unit.
*/
`ifndef GSC_DEFS_SVH
`define GSC_DEFS_SVH

`define GSC_CTL_INIT_READY 0
`define GSC_CTL_CLEAR 1
`define GSC_CTL_NO_CRC 2
`define GSC_CTL_NO_RESEND 3
`define GSC_CTL_SYNC_EN 4
`define GSC_CTL_SYNC_RUN 5

`define GSC_ST_STRAP 0
`define GSC_ST_BAUD_ERR 1
`define GSC_ST_PARITY_ERR 2
`define GSC_ST_STOP_ERR 3
`define GSC_ST_TMO_CFG_ERR 4
`define GSC_ST_DELAY_ERR 5
`define GSC_ST_ADDR_ERR 6
`define GSC_ST_EEP_CRC_ERR 7
`define GSC_ST_CNT_ERR 8
`define GSC_ST_LEN_ERR 9
`define GSC_ST_FUN_ERR 10
`define GSC_ST_INOUT_ERR 11
`define GSC_ST_TIMEOUT 16
`define GSC_ST_INIT_VAL 17
`define GSC_ST_NODE_ERR 18
`define GSC_ST_FC_ERR 19
`define GSC_ST_CRC_ERR 20
`define GSC_ST_SYNC 21
`define GSC_ST_DEFAULT 24
`define GSC_ST_TWO_STOP 25
`define GSC_ST_ODD 26
`define GSC_ST_EVEN 27
`define GSC_ST_BAUD_LO 28
`define GSC_ST_BAUD_HI 31

`define GSC_STATUS_RESET 32'h0000_0000
`define GSC_CMD_COUNT_MAX 16'h012C
`define GSC_DELAY_MS_MAX 16'h00FF
`define GSC_TMO_MS_MAX 16'h00FF
`define GSC_BAUD_CODE_MIN 4'h3
`define GSC_BAUD_CODE_MAX 4'hD
`define GSC_BAUD_CFG_MAX 4'hA
`define GSC_BAUD_CODE_DEFAULT 4'hA

`endif

// File: logic/gsc_pkg.sv
/*
  Types of the gateway status and control words.
  Assumes gsc_defs.svh is on the include path.
*/
package gsc_pkg;

  typedef enum logic [1:0] {
    GSC_PAR_NONE,
    GSC_PAR_EVEN,
    GSC_PAR_ODD,
    GSC_PAR_BAD
  } gsc_parity_e;

  typedef enum logic [1:0] {
    GSC_BOOT_CHECK,
    GSC_BOOT_RUN,
    GSC_BOOT_ERROR,
    GSC_BOOT_DEBUG
  } gsc_boot_e;

  // Configuration as read from non-volatile storage
  typedef struct packed {
    logic [3:0] baudCode;
    gsc_parity_e parity;
    logic [1:0] stopBits;
    logic [15:0] cmdCount;
    logic [15:0] delayMs;
    logic [15:0] timeoutMs;
    logic cmdFunctionBad;
    logic cmdLengthBad;
    logic addressBad;
    logic eepCrcBad;
    logic inOutMaxBad;
  } gsc_config_s;

  // One-cycle events from the Modbus engine
  typedef struct packed {
    logic crcBad;
    logic functionCodeBad;
    logic nodeIdBad;
    logic timeout;
  } gsc_events_s;

  // Steering sent to the Modbus engine and sync logic
  typedef struct packed {
    logic syncEnable;
    logic syncRun;
    logic noResend;
    logic skipCrc;
    logic initialReady;
  } gsc_steer_s;

endpackage : gsc_pkg

// File: logic/gsc_sticky_bit.sv
/*
  One sticky flag: set by an event, cleared on request, set wins.
  Assumes a synchronous active-low reset on core_clk.
*/
`timescale 1ns/1ns
`default_nettype none

module gsc_sticky_bit (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic setPulse,
  input wire logic clearReq,
  output logic flag
);

  wire logic next_flag = setPulse | (flag & ~clearReq);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end

endmodule : gsc_sticky_bit

`default_nettype wire

// File: sim/gsc_master_model.sv
/*
  Fieldbus master model: sends control words with a one-cycle strobe.
  Assumes the bench calls send between falling edges.
*/
`timescale 1ns/1ns
`default_nettype none

module gsc_master_model (
  input wire logic core_clk,
  output var logic [31:0] controlWord,
  output var logic controlWrite
);
  initial begin
    controlWord = '0;
    controlWrite = 1'b0;
  end

  task automatic send(input logic [31:0] w);
    @(negedge core_clk);
    controlWord = w;
    controlWrite = 1'b1;
    @(negedge core_clk);
    controlWrite = 1'b0;
    // Word is unqualified now, so show garbage rather than the old value
    controlWord = ~w;
  endtask : send
endmodule : gsc_master_model

`default_nettype wire

// File: sim/gsc_status_monitor.sv
/*
  Checker of the status and control block ports.
  Assumes it is bound to gsc_status_control.
*/
`timescale 1ns/1ns
`default_nettype none

module gsc_status_monitor
  import gsc_pkg::*;
#(
  parameter int CTRL_WIDTH = 32,
  parameter int STATUS_WIDTH = 32
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [CTRL_WIDTH-1:0] controlWord,
  input wire logic controlWrite,
  input wire logic initStrapShorted,
  input wire gsc_events_s engineEvents,
  input wire logic [STATUS_WIDTH-1:0] statusWord,
  input wire gsc_steer_s steer,
  input wire logic syncActive,
  input wire logic debugMode
);
  localparam logic [31:0] ERR = 32'h001D_0FFE;
  wire logic clr = controlWrite && controlWord[1];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sync_run_a:
    assert property (controlWrite |-> ##2 syncActive == $past(controlWord[5] & controlWord[4], 2))
    else $error("sync state wrong");
  sync_enable_a:
    assert property (controlWrite && !controlWord[4] |-> ##2 !steer.syncEnable && !syncActive)
    else $error("sync enabled without bit 4");
  no_resend_a:
    assert property (controlWrite |-> ##2 steer.noResend == $past(controlWord[3], 2))
    else $error("no resend wrong");
  clear_all_a:
    assert property (clr |=> statusWord == '0)
    else $error("status not cleared");
  sticky_flags_a:
    assert property (!clr |=> (statusWord & $past(statusWord) & ERR) == ($past(statusWord) & ERR))
    else $error("error flag dropped");
  timeout_flag_a:
    assert property (engineEvents.timeout ##1 !clr |=> statusWord[16])
    else $error("timeout not flagged");
  strap_debug_a:
    assert property (initStrapShorted ##1 !clr ##1 !clr |=> debugMode && statusWord[0])
    else $error("strap not seen");
  baud_code_a:
    assert property (statusWord[31:28] inside {4'h0, [4'h3:4'hA]})
    else $error("baud code out of range");
endmodule : gsc_status_monitor

bind gsc_status_control gsc_status_monitor #(
  .CTRL_WIDTH(CTRL_WIDTH), .STATUS_WIDTH(STATUS_WIDTH)) MON (
  .core_clk(core_clk), .rst_n(rst_n), .controlWord(controlWord),
  .controlWrite(controlWrite), .initStrapShorted(initStrapShorted),
  .engineEvents(engineEvents), .statusWord(statusWord), .steer(steer),
  .syncActive(syncActive), .debugMode(debugMode));

`default_nettype wire

// File: sim/tb_gateway_status_control_words.sv
/*
  Self-checking bench of the status and control block with a reference model.
  Assumes the design package and the master model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_gateway_status_control_words;
  import gsc_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic strap = 1'b0;
  logic cfgLoad = 1'b0;
  logic cfgDef = 1'b0;
  gsc_config_s cfg = '0;
  gsc_events_s ev = '0;
  logic [31:0] controlWord, statusWord;
  logic controlWrite, syncActive, errorLed, debugMode;
  gsc_steer_s steer;
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int i;
  logic [5:0] ctl = '0;
  logic [31:0] flags = '0;
  logic [7:0] serial = '0;
  logic initv = 1'b0;
  logic led = 1'b0;
  logic dbg = 1'b0;

  always #4 core_clk = ~core_clk;

  gsc_master_model MASTER (.core_clk(core_clk), .controlWord(controlWord),
    .controlWrite(controlWrite));
  gsc_status_control #(.CTRL_WIDTH(32), .STATUS_WIDTH(32)) DUT (.core_clk(core_clk),
    .rst_n(rst_n), .controlWord(controlWord), .controlWrite(controlWrite),
    .initStrapShorted(strap), .configData(cfg), .configLoad(cfgLoad),
    .configFromDefaults(cfgDef), .engineEvents(ev), .statusWord(statusWord),
    .steer(steer), .syncActive(syncActive), .errorLed(errorLed), .debugMode(debugMode));

  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      test_done();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic compare();
    repeat (3) @(negedge core_clk);
    chk("status", statusWord, {serial, 3'(ctl[5] & ctl[4]), flags[20:18], initv,
      flags[16:1], dbg});
    chk("steer", 32'(steer), 32'({ctl[4], ctl[5] & ctl[4], ctl[3:2], ctl[0]}));
    chk("sync", 32'(syncActive), 32'(ctl[5] & ctl[4]));
    chk("led", 32'(errorLed), 32'(led));
    chk("debug", 32'(debugMode), 32'(dbg));
  endtask : compare

  task automatic pulse(input gsc_events_s e);
    @(negedge core_clk);
    ev = e;
    @(negedge core_clk);
    ev = '0;
  endtask : pulse

  task automatic op(input logic wr, input logic [31:0] w, input gsc_events_s e);
    fork
      if (wr) MASTER.send(w);
      pulse(e);
    join
    if (wr && w[1]) flags = '0;
    flags[20] |= e.crcBad & ~ctl[2];
    flags[19:18] |= {e.functionCodeBad, e.nodeIdBad};
    flags[16] |= e.timeout;
    if (wr) ctl = w[5:0];
    compare();
  endtask : op

  task automatic load(input gsc_config_s c, input logic d);
    logic [31:0] e;
    e = '0;
    e[1] = c.baudCode < 4'h3 || c.baudCode > 4'hA;
    e[2] = c.parity == GSC_PAR_BAD;
    e[3] = c.stopBits != 2'h1 && c.stopBits != 2'h2;
    e[5:4] = {c.delayMs > 16'h00FF, c.timeoutMs > 16'h00FF};
    e[11:6] = {c.inOutMaxBad, c.cmdFunctionBad, c.cmdLengthBad, c.cmdCount > 16'h012C,
      c.eepCrcBad, c.addressBad};
    @(negedge core_clk);
    cfg = c;
    cfgLoad = 1'b1;
    cfgDef = d;
    @(negedge core_clk);
    cfgLoad = 1'b0;
    cfg = gsc_config_s'(~c);
    flags |= e;
    led = (e != '0);
    if (e == '0) begin
      serial = {c.baudCode, c.parity == GSC_PAR_EVEN, c.parity == GSC_PAR_ODD, c.stopBits == 2'h2,
        c.baudCode == 4'hA && c.parity == GSC_PAR_NONE && c.stopBits == 2'h1};
      initv = d;
    end
    compare();
  endtask : load

  initial begin
    gsc_config_s c;
    logic g;
    void'($urandom(32'h9AAAC791));
    repeat (20) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'b1;
    compare();
    for (i = 0; i < 6; i++) op(1'b1, 32'h1 << i, '0);
    op(1'b1, 32'h34, gsc_events_s'(4'h8));
    for (i = 0; i < 60; i++) begin
      case ($urandom_range(2))
        0: begin
          // Bad configs sit near the limits so both sides of each bound are hit
          g = 1'($urandom_range(1));
          c.baudCode = g ? 4'(3 + $urandom_range(7)) : 4'($urandom);
          c.parity = gsc_parity_e'(g ? $urandom_range(2) : $urandom_range(3));
          c.stopBits = g ? 2'(1 + $urandom_range(1)) : 2'($urandom);
          c.cmdCount = 16'(g ? $urandom_range(300) : 290 + $urandom_range(20));
          c.delayMs = 16'(g ? $urandom_range(255) : 250 + $urandom_range(10));
          c.timeoutMs = 16'(g ? $urandom_range(255) : 250 + $urandom_range(10));
          {c.cmdFunctionBad, c.cmdLengthBad, c.addressBad, c.eepCrcBad,
            c.inOutMaxBad} = g ? 5'h0 : 5'(1 << $urandom_range(5));
          load(c, g & 1'($urandom));
        end
        1: op(1'b1, $urandom, gsc_events_s'(4'($urandom)));
        default: op(1'b0, '0, gsc_events_s'(4'($urandom)));
      endcase
    end
    op(1'b1, 32'h2, gsc_events_s'(4'h1));
    strap = 1'b1;
    dbg = 1'b1;
    // Debug mode replaces error mode, so the error indicator goes dark
    led = 1'b0;
    op(1'b1, 32'h2, '0);
    test_done();
  end
endmodule : tb_gateway_status_control_words

`default_nettype wire
